// ===== rpw_pkg.sv
// Shared constants and types for the ring port wrap controller
package rpw_pkg;
    // Port count and trunk placement (last two ports form the trunk pair)
    localparam int DEFAULT_PORTS = 18;
    localparam int RING_OUT_FROM_END = 2;
    localparam int RING_IN_FROM_END = 1;
    localparam int TRUNK_RO = 0;
    localparam int TRUNK_RI = 1;
    // Segment codes: 0 isolated, 1..10 backplane rings
    localparam int SEG_W = 4;
    localparam logic [SEG_W-1:0] SEG_ISOLATED = 4'h0;
    localparam logic [SEG_W-1:0] SEG_MAX = 4'hA;
    // Unwrap limit counter
    localparam int LIMIT_W = 8;
    localparam logic [LIMIT_W-1:0] LIMIT_RESET = 8'h00;
    localparam logic [LIMIT_W-1:0] LIMIT_SAT = 8'hFF;
    // Configuration switch field positions (switch n is bit n-1)
    localparam int DIP_W = 8;
    localparam int DIP_SEG_LSB = 0;
    localparam int DIP_SPEED_BIT = 5;
    localparam logic [DIP_W-1:0] DIP_RESET = 8'h00;
    // Timing
    localparam int CLK_MHZ = 200;
    localparam int RECOVER_WAIT_US = 10;
    localparam int RECOVER_WAIT_CYC = RECOVER_WAIT_US * CLK_MHZ;
    localparam int RETEST_US = 1000;
    localparam int RETEST_CYC = RETEST_US * CLK_MHZ;
    localparam logic [1:0] STRAP_CAPTURE_AT = 2'h3;

    // Per-port wrap state
    typedef enum logic [2:0] {
        PS_DISABLED = 3'h0,
        PS_OPEN = 3'h1,
        PS_WRAPPED = 3'h2,
        PS_LIMIT = 3'h3,
        PS_RATE = 3'h4
    } rpw_port_state_t;

    // Module beacon recovery sequence
    typedef enum logic [1:0] {
        RS_IDLE = 2'h0,
        RS_TRUNK_WAIT = 2'h1,
        RS_RETEST = 2'h2,
        RS_REMOVE = 2'h3
    } rpw_rec_state_t;
endpackage : rpw_pkg

// ===== rpw_port_if.sv
// Signals between the module controller and one port controller
interface rpw_port_if;
    import rpw_pkg::*;
    logic enable;
    logic beacon;
    logic wrapReq;
    logic rateFault;
    logic phantom;
    logic phantomEdge;
    logic staticEn;
    logic unwrapAllowed;
    logic [SEG_W-1:0] reqSeg;
    logic unwrapTaken;
    logic isolated;
    logic limitHit;
    logic rateConflict;
    logic [SEG_W-1:0] curSeg;
    modport ctrl (output enable, beacon, wrapReq, rateFault, phantom, phantomEdge, staticEn,
                  unwrapAllowed, reqSeg, input unwrapTaken, isolated, limitHit, rateConflict,
                  curSeg);
    modport port (input enable, beacon, wrapReq, rateFault, phantom, phantomEdge, staticEn,
                  unwrapAllowed, reqSeg, output unwrapTaken, isolated, limitHit, rateConflict,
                  curSeg);
endinterface : rpw_port_if

// ===== rpw_port_ctrl.sv
// Wrap state and segment placement of one port
module rpw_port_ctrl
    import rpw_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Link to the module controller
    rpw_port_if.port pif
);
    typedef struct packed {
        rpw_port_state_t state;
        logic [SEG_W-1:0] curSeg;
    } rpw_port_reg_t;

    rpw_port_reg_t st;
    rpw_port_reg_t next_st;

    // Wrap decisions and segment moves
    always_comb begin
        next_st = st;
        pif.unwrapTaken = 1'b0;
        if (!pif.enable) begin
            next_st.state = PS_DISABLED; // Disable then enable clears every wrap
        end else begin
            unique case (st.state)
                PS_DISABLED: next_st.state = PS_OPEN;
                PS_OPEN: begin
                    if (pif.rateFault) begin
                        next_st.state = PS_RATE;
                    end else if (pif.beacon || pif.wrapReq) begin
                        next_st.state = PS_WRAPPED;
                    end
                end
                PS_WRAPPED: begin
                    if (pif.phantomEdge && pif.unwrapAllowed) begin
                        next_st.state = PS_OPEN;
                        pif.unwrapTaken = 1'b1;
                    end else if (pif.phantomEdge) begin
                        next_st.state = PS_LIMIT;
                    end
                end
                PS_LIMIT: next_st.state = PS_LIMIT; // Phantom ignored
                PS_RATE: begin
                    if (pif.phantomEdge) begin
                        next_st.state = PS_OPEN;
                    end
                end
                default: next_st.state = PS_DISABLED;
            endcase
        end
        // Static switch holds the move while the station still drives phantom
        if (pif.reqSeg != st.curSeg && !(pif.staticEn && pif.phantom)) begin
            next_st.curSeg = pif.reqSeg;
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '{state: PS_DISABLED, curSeg: SEG_ISOLATED};
        end else begin
            st <= next_st;
        end
    end

    // Status decodes of the state flops
    assign pif.isolated = (st.state != PS_OPEN);
    assign pif.limitHit = (st.state == PS_LIMIT);
    assign pif.rateConflict = (st.state == PS_RATE);
    assign pif.curSeg = st.curSeg;

    a_beacon_wrap: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pif.enable && st.state == PS_OPEN && !pif.rateFault && pif.beacon |=> pif.isolated)
        else $error("beacon did not wrap port");
    a_limit_stays: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pif.limitHit && pif.enable |=> pif.limitHit && pif.isolated)
        else $error("port left limit state while enabled");
    a_phantom_unwrap: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pif.enable && st.state == PS_WRAPPED && pif.phantomEdge && pif.unwrapAllowed
        |=> !pif.isolated)
        else $error("phantom transition did not unwrap");
    a_static_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pif.staticEn && pif.phantom && pif.reqSeg != pif.curSeg |=> $stable(pif.curSeg))
        else $error("port moved while phantom present");
    a_move_now: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !pif.staticEn && pif.reqSeg != pif.curSeg |=> pif.curSeg == $past(pif.reqSeg))
        else $error("port move was delayed");
endmodule : rpw_port_ctrl

// ===== rpw_wrap_ctrl.sv
// Module level wrap recovery, trunk pairing and switch configuration
// Contract
// - A port showing a beacon condition is wrapped off its segment.
// - A wrapped port unwraps on a phantom transition or disable then enable.
// - A module unwrap limit from 0 to 255 bounds phantom driven unwraps.
// - Past the limit the port stays wrapped until re-enabled, reporting limit status.
// - The unwrap count clears on any successful insertion and on reset.
// - Static switch on: segment move waits until the station drops phantom.
// - Static switch off: segment move happens at once.
// - As trunks, port 17 is ring-out and port 18 is ring-in, fixed.
// - Assigning one trunk to a segment assigns the other to it too.
// - A strap picks trunk pair or lobe use for the last two ports.
// - Signal mode: trunk opens on signal, needs jitter cleaner, no phantom.
// - Signal mode beacon: wrap trunks, retest on recovery, else remove ports.
// - Phantom mode: drive ring-in phantom, insert only with ring-out phantom.
// - Phantom mode: phantom drive fault wraps trunks at once, else beacon recovery.
// - Module switching variant puts all ports on one segment or isolates all.
// - Ports join one of ten backplane rings or the isolated segment.
// - Switch 6 off enables speed detection, on disables it.
// - Switches apply without a hub manager or with the override set.
// - Switches 1 to 4 give one segment code for all ports.
// - With speed detection on, a wrong speed insertion wraps and reports conflict.
module rpw_wrap_ctrl
    import rpw_pkg::*;
#(
    parameter int NUM_PORTS = DEFAULT_PORTS,
    parameter bit MODULE_SWITCH = 1'b0,
    parameter int RECOVER_WAIT_CYCLES = RECOVER_WAIT_CYC,
    parameter int RETEST_CYCLES = RETEST_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // Pins from outside the clock domain
    input wire logic [NUM_PORTS-1:0] phantomPin,
    input wire logic [DIP_W-1:0] dipSwitchPin,
    input wire logic trunkStrapPin,
    input wire logic ringOutPhantomPin,
    input wire logic phantomDriveFaultPin,
    input wire logic [1:0] trunkSignalPin,
    // Station and ring events on this clock
    input wire logic [NUM_PORTS-1:0] beaconFault,
    input wire logic [NUM_PORTS-1:0] insertOk,
    input wire logic [NUM_PORTS-1:0] speedMismatch,
    input wire logic beaconBlamed,
    input wire logic ringRecovered,
    // Administrative configuration
    input wire logic [NUM_PORTS-1:0] portEnable,
    input wire logic [NUM_PORTS-1:0] staticSwitchEn,
    input wire logic [NUM_PORTS-1:0][SEG_W-1:0] portSegReq,
    input wire logic [SEG_W-1:0] moduleSegReq,
    input wire logic [SEG_W-1:0] trunkSegReq,
    input wire logic [1:0] trunkEnable,
    input wire logic trunkSignalMode,
    input wire logic jitterCleanerPresent,
    input wire logic [LIMIT_W-1:0] unwrapLimit,
    input wire logic speedDetectEnable,
    input wire logic hubManagerPresent,
    input wire logic switchConfigOverride,
    // Status
    output logic [NUM_PORTS-1:0] portIsolated,
    output logic [NUM_PORTS-1:0] unwrapLimitHitStatus,
    output logic [NUM_PORTS-1:0] rateConflictStatus,
    output logic [NUM_PORTS-1:0][SEG_W-1:0] portSegment,
    output logic trunkPairActive,
    output logic ringInPhantomDrive,
    output logic trunkRetestPending,
    output logic speedDetectActive
);
    localparam int RO_IDX = NUM_PORTS - RING_OUT_FROM_END;
    localparam int RI_IDX = NUM_PORTS - RING_IN_FROM_END;
    localparam int LONGEST = (RETEST_CYCLES > RECOVER_WAIT_CYCLES) ? RETEST_CYCLES
                                                                   : RECOVER_WAIT_CYCLES;
    localparam int TIMER_W = $clog2(LONGEST + 1);
    localparam int IDX_W = $clog2(NUM_PORTS + 1);
    localparam int CNT_W = $clog2(NUM_PORTS + 1);
    // Synchroniser bit positions
    localparam int P_DIP = NUM_PORTS;
    localparam int P_STRAP = P_DIP + DIP_W;
    localparam int P_ROPH = P_STRAP + 1;
    localparam int P_FAULT = P_ROPH + 1;
    localparam int P_SIG = P_FAULT + 1;
    localparam int PIN_W = P_SIG + 2;

    // Elaboration check on sizes the logic cannot serve
    if (NUM_PORTS < 3 || RECOVER_WAIT_CYCLES < 1 || RETEST_CYCLES < 1) begin : g_bad_size
        $error("rpw_wrap_ctrl: port count or timer lengths out of range");
    end

    typedef struct packed {
        logic [PIN_W-1:0] syncA;
        logic [PIN_W-1:0] syncB;
        logic [NUM_PORTS-1:0] phantomPrev;
        logic [1:0] capCnt;
        logic strapTrunk;
        logic [LIMIT_W-1:0] unwrapCount;
        logic [1:0] trunkIso;
        logic ringInDrive;
        rpw_rec_state_t recState;
        logic [TIMER_W-1:0] timer;
        logic [IDX_W-1:0] removeIdx;
        logic trunkHold;
        logic retestPending;
        logic [NUM_PORTS-1:0] wrapPulse;
    } rpw_wrap_reg_t;

    rpw_wrap_reg_t st;
    rpw_wrap_reg_t next_st;

    rpw_port_if pif[NUM_PORTS] ();

    logic [NUM_PORTS-1:0] phantomSync;
    logic [DIP_W-1:0] dipSync;
    logic useDip;
    logic signalMode;
    logic [SEG_W-1:0] sharedSeg;
    logic [NUM_PORTS-1:0] unwrapTakenVec;
    logic [NUM_PORTS-1:0] fsmIsolated;
    logic [NUM_PORTS-1:0] fsmLimit;
    logic [NUM_PORTS-1:0] fsmRate;
    logic insertAny;
    logic [IDX_W-1:0] lobeCount;

    // Second synchroniser stage is the only reader of the first
    assign phantomSync = st.syncB[NUM_PORTS-1:0];
    assign dipSync = st.syncB[P_STRAP-1:P_DIP];
    assign useDip = !hubManagerPresent || switchConfigOverride;
    assign signalMode = trunkSignalMode;
    assign trunkPairActive = st.strapTrunk;
    assign insertAny = |insertOk;
    assign lobeCount = st.strapTrunk ? IDX_W'(NUM_PORTS - 2) : IDX_W'(NUM_PORTS);
    assign speedDetectActive = useDip ? !dipSync[DIP_SPEED_BIT] : speedDetectEnable;

    // One segment for every port under switches or the module switching variant
    always_comb begin
        sharedSeg = useDip ? dipSync[DIP_SEG_LSB +: SEG_W] : moduleSegReq;
        if (sharedSeg > SEG_MAX) begin
            sharedSeg = SEG_ISOLATED; // Unknown codes fall back to isolation
        end
    end

    // Per-port connection to the port controllers
    for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
        localparam bit IS_TRUNK = (i == RO_IDX) || (i == RI_IDX);
        logic pairTrunk;
        logic [SEG_W-1:0] ownSeg;
        assign pairTrunk = IS_TRUNK && st.strapTrunk;
        // Trunk pair shares one segment request
        assign ownSeg = pairTrunk ? trunkSegReq : portSegReq[i];
        assign pif[i].enable = portEnable[i] && !pairTrunk;
        assign pif[i].beacon = beaconFault[i];
        assign pif[i].wrapReq = st.wrapPulse[i];
        assign pif[i].rateFault = speedDetectActive && speedMismatch[i];
        assign pif[i].phantom = phantomSync[i];
        assign pif[i].phantomEdge = phantomSync[i] ^ st.phantomPrev[i];
        assign pif[i].staticEn = staticSwitchEn[i] && !pairTrunk;
        assign pif[i].unwrapAllowed = st.unwrapCount < unwrapLimit;
        assign pif[i].reqSeg = (useDip || MODULE_SWITCH) ? sharedSeg
                             : ((ownSeg > SEG_MAX) ? SEG_ISOLATED : ownSeg);
        assign unwrapTakenVec[i] = pif[i].unwrapTaken;
        assign fsmIsolated[i] = pif[i].isolated;
        assign fsmLimit[i] = pif[i].limitHit;
        assign fsmRate[i] = pif[i].rateConflict;
        assign portSegment[i] = pif[i].curSeg;
        rpw_port_ctrl u_port (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .pif(pif[i].port)
        );
    end

    // Trunk ports take their isolation from the trunk gate when paired
    always_comb begin
        portIsolated = fsmIsolated;
        unwrapLimitHitStatus = fsmLimit;
        rateConflictStatus = fsmRate;
        if (st.strapTrunk) begin
            portIsolated[RO_IDX] = st.trunkIso[TRUNK_RO];
            portIsolated[RI_IDX] = st.trunkIso[TRUNK_RI];
        end
    end
    assign ringInPhantomDrive = st.ringInDrive;
    assign trunkRetestPending = st.retestPending;

    // Next state of the module controller
    always_comb begin
        logic [CNT_W-1:0] taken;
        logic [LIMIT_W:0] sum;
        logic gateOk;
        taken = '0;
        sum = '0;
        gateOk = 1'b0;
        next_st = st;
        next_st.syncA = {trunkSignalPin, phantomDriveFaultPin, ringOutPhantomPin,
                         trunkStrapPin, dipSwitchPin, phantomPin};
        next_st.syncB = st.syncA;
        next_st.phantomPrev = phantomSync;
        next_st.wrapPulse = '0;
        // Strap is caught once after reset release, when the synchroniser is full
        if (st.capCnt != STRAP_CAPTURE_AT) begin
            next_st.capCnt = st.capCnt + 2'h1;
            if (st.capCnt + 2'h1 == STRAP_CAPTURE_AT) begin
                next_st.strapTrunk = st.syncB[P_STRAP];
            end
        end
        // Saturating unwrap count; an insertion clears it
        for (int k = 0; k < NUM_PORTS; k++) begin
            taken = taken + CNT_W'(unwrapTakenVec[k]);
        end
        sum = {1'b0, st.unwrapCount} + (LIMIT_W + 1)'(taken);
        if (insertAny) begin
            next_st.unwrapCount = LIMIT_RESET;
        end else if (sum > {1'b0, LIMIT_SAT}) begin
            next_st.unwrapCount = LIMIT_SAT;
        end else begin
            next_st.unwrapCount = sum[LIMIT_W-1:0];
        end
        // Trunk gates per compatibility mode
        for (int t = 0; t < 2; t++) begin
            if (signalMode) begin
                gateOk = jitterCleanerPresent && st.syncB[P_SIG + t];
            end else begin
                gateOk = st.syncB[P_ROPH] && !st.syncB[P_FAULT];
            end
            next_st.trunkIso[t] = !(st.strapTrunk && trunkEnable[t] && gateOk && !st.trunkHold);
        end
        next_st.ringInDrive = st.strapTrunk && !signalMode && trunkEnable[TRUNK_RI];
        // Beacon recovery sequence; in phantom mode it only sees faults phantom missed
        unique case (st.recState)
            RS_IDLE: begin
                next_st.retestPending = 1'b0;
                if (beaconBlamed && st.strapTrunk) begin
                    next_st.recState = RS_TRUNK_WAIT;
                    next_st.trunkHold = 1'b1;
                    next_st.timer = TIMER_W'(RECOVER_WAIT_CYCLES);
                end else if (beaconBlamed) begin
                    next_st.recState = RS_REMOVE;
                    next_st.removeIdx = '0;
                    next_st.timer = '0;
                end
            end
            RS_TRUNK_WAIT: begin
                if (st.timer != '0) begin
                    next_st.timer = st.timer - TIMER_W'(1);
                end else if (ringRecovered) begin
                    next_st.recState = RS_RETEST;
                    next_st.retestPending = 1'b1;
                    next_st.timer = TIMER_W'(RETEST_CYCLES);
                end else begin
                    next_st.recState = RS_REMOVE;
                    next_st.removeIdx = '0;
                end
            end
            RS_RETEST: begin
                // Trunks stay held until the retest time, then are tried again
                if (st.timer != '0) begin
                    next_st.timer = st.timer - TIMER_W'(1);
                end else begin
                    next_st.recState = RS_IDLE;
                    next_st.trunkHold = 1'b0;
                    next_st.retestPending = 1'b0;
                end
            end
            RS_REMOVE: begin
                // Lobe ports go one by one, a wait apart, until the ring heals
                if (ringRecovered || st.removeIdx >= lobeCount) begin
                    next_st.recState = RS_IDLE;
                    next_st.trunkHold = 1'b0;
                end else if (st.timer != '0) begin
                    next_st.timer = st.timer - TIMER_W'(1);
                end else begin
                    next_st.wrapPulse[st.removeIdx] = 1'b1;
                    next_st.removeIdx = st.removeIdx + IDX_W'(1);
                    next_st.timer = TIMER_W'(RECOVER_WAIT_CYCLES);
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '{syncA: '0, syncB: '0, phantomPrev: '0, capCnt: 2'h0, strapTrunk: 1'b0,
                    unwrapCount: LIMIT_RESET, trunkIso: 2'h3, ringInDrive: 1'b0,
                    recState: RS_IDLE, timer: '0, removeIdx: '0, trunkHold: 1'b0,
                    retestPending: 1'b0, wrapPulse: '0};
        end else begin
            st <= next_st;
        end
    end

    a_count_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
        insertAny |=> st.unwrapCount == LIMIT_RESET)
        else $error("unwrap count not cleared by insertion");
    a_count_sat: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st.unwrapCount == LIMIT_SAT && !insertAny |=> st.unwrapCount == LIMIT_SAT)
        else $error("unwrap count rolled over");
    a_pair_segment: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st.strapTrunk [*2] |-> portSegment[RO_IDX] == portSegment[RI_IDX])
        else $error("trunk pair on different segments");
    a_needs_cleaner: assert property (@(posedge sys_clk) disable iff (sys_rst)
        signalMode && !jitterCleanerPresent |=> st.trunkIso == 2'h3)
        else $error("trunk opened without jitter cleaner");
    a_fault_wraps: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !signalMode && st.syncB[P_FAULT] |=> st.trunkIso == 2'h3)
        else $error("phantom drive fault did not wrap trunks");
    a_ri_drive: assert property (@(posedge sys_clk) disable iff (sys_rst)
        ringInPhantomDrive |-> $past(st.strapTrunk && !signalMode && trunkEnable[TRUNK_RI]))
        else $error("ring-in phantom driven outside phantom mode");
    a_trunk_first: assert property (@(posedge sys_clk) disable iff (sys_rst)
        st.recState == RS_IDLE && beaconBlamed && st.strapTrunk
        |=> st.trunkHold && st.recState == RS_TRUNK_WAIT ##1 st.trunkIso == 2'h3)
        else $error("trunks not wrapped first on beacon");

    c_retest: cover property (@(posedge sys_clk) disable iff (sys_rst)
        st.recState == RS_TRUNK_WAIT ##1 st.recState == RS_RETEST);
    c_remove: cover property (@(posedge sys_clk) disable iff (sys_rst) |st.wrapPulse);
    c_limit: cover property (@(posedge sys_clk) disable iff (sys_rst) |unwrapLimitHitStatus);
endmodule : rpw_wrap_ctrl

// ===== rpw_station_model.sv
// Ring station model driving the phantom level of each lobe
module rpw_station_model
    import rpw_pkg::*;
#(
    parameter int N = DEFAULT_PORTS
) (
    // Clock and station power commands
    input wire logic sys_clk,
    input wire logic [N-1:0] power,
    // Phantom toward the hub
    output logic [N-1:0] phantomPin
);
    timeunit 1ns;
    timeprecision 100ps;
    // Powered stations raise phantom, dropped ones release it to low
    always @(posedge sys_clk) begin
        phantomPin <= power;
    end
endmodule : rpw_station_model

// ===== rpw_wrap_ctrl_tb.sv
// Self-checking bench for the ring port wrap controller
module rpw_wrap_ctrl_tb
    import rpw_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int N = DEFAULT_PORTS;
    logic sys_clk = 1'b0, sys_rst = 1'b1, strap = 1'b1, hmPres = 1'b1, jc = 1'b1;
    logic sigMode = 1'b1, roPh = 1'b0, dFlt = 1'b0, blame = 1'b0, recov = 1'b0;
    logic [1:0] tEn = 2'h3;
    logic [N-1:0] power = 18'h00002, beacon = '0, insOk = '0, spdBad = '0, pEn = '1;
    logic [N-1:0] stat = 18'h00002, phant, iso, limHit, rate;
    logic [N-1:0][SEG_W-1:0] pSeg = {N{4'h1}}, seg;
    logic [DIP_W-1:0] dip = DIP_RESET;
    logic [SEG_W-1:0] tSeg = 4'h3, r;
    logic [LIMIT_W-1:0] lim = 8'h01;
    logic [7:0] rnd = 8'h46;
    logic pair, sda, riDrv, rtp;
    int badCount = 0, checksDone = 0;
    // Half period of a 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;
    rpw_station_model #(.N(N)) u_sta (.sys_clk(sys_clk), .power(power), .phantomPin(phant));
    // Trunk signal, speed enable and override stay tied; trunk and recovery inputs are driven
    rpw_wrap_ctrl #(.RECOVER_WAIT_CYCLES(4), .RETEST_CYCLES(20)) u_dut (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .phantomPin(phant), .dipSwitchPin(dip), .trunkStrapPin(strap),
        .ringOutPhantomPin(roPh), .phantomDriveFaultPin(dFlt), .trunkSignalPin(2'h3),
        .beaconFault(beacon), .insertOk(insOk), .speedMismatch(spdBad), .beaconBlamed(blame),
        .ringRecovered(recov), .portEnable(pEn), .staticSwitchEn(stat), .portSegReq(pSeg),
        .moduleSegReq(tSeg), .trunkSegReq(tSeg), .trunkEnable(tEn), .trunkSignalMode(sigMode),
        .jitterCleanerPresent(jc), .unwrapLimit(lim), .speedDetectEnable(1'b1),
        .hubManagerPresent(hmPres), .switchConfigOverride(1'b0), .portIsolated(iso),
        .unwrapLimitHitStatus(limHit), .rateConflictStatus(rate), .portSegment(seg),
        .trunkPairActive(pair), .ringInPhantomDrive(riDrv), .trunkRetestPending(rtp),
        .speedDetectActive(sda));
    // Pseudo random source, fixed start
    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr
    // Codes past the last ring fall back to isolation
    function automatic logic [3:0] dip_seg(input logic [3:0] k);
        return (k > SEG_MAX) ? SEG_ISOLATED : k;
    endfunction : dip_seg
    task tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    // Sample a little after the edge so design updates have landed
    task look(input int n);
        tick(n);
        #1;
    endtask : look
    task chk(input logic [3:0] got, input logic [3:0] exp, input string m);
        checksDone++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask : chk
    task report_and_stop;
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    // Beacon on port 0, then move the station phantom to level p
    task hit_unwrap(input logic p);
        tick(1);
        beacon[0] <= 1'b1;
        tick(1);
        beacon[0] <= 1'b0;
        tick(2);
        power[0] <= p;
        look(6);
    endtask : hit_unwrap
    initial begin
        look(2);
        chk(iso[3:0], 4'hF, "reset iso");
        tick(1);
        sys_rst <= 1'b0;
        look(6);
        chk(iso[0], 1'b0, "open");
        chk(pair, 1'b1, "strap");
        chk(iso[N-2], 1'b0, "trunk open");
        chk(seg[N-1], 4'h3, "ring-in seg");
        hit_unwrap(1'b1);
        chk(iso[0], 1'b0, "phantom unwrap");
        hit_unwrap(1'b0);
        chk(limHit[0], 1'b1, "limit");
        tick(1);
        insOk[1] <= 1'b1;
        tick(1);
        insOk[1] <= 1'b0;
        power[0] <= 1'b1;
        look(6);
        chk(iso[0], 1'b1, "limit holds");
        tick(1);
        pEn[0] <= 1'b0;
        tick(2);
        pEn[0] <= 1'b1;
        look(4);
        chk(limHit[0], 1'b0, "re-enable");
        hit_unwrap(1'b0);
        chk(iso[0], 1'b0, "count cleared");
        tick(1);
        lim <= 8'h00;
        hit_unwrap(1'b1);
        chk(iso[0], 1'b1, "zero limit");
        $display("test wrap done");
        for (int i = 0; i < 4; i++) begin
            tick(1);
            rnd = lfsr(rnd);
            r = 4'(rnd % 10 + 1);
            pSeg[1] <= r;
            pSeg[2] <= r;
            tSeg <= r;
            look(4);
            chk(seg[2], r, "free move");
            chk(seg[N-2], r, "ring-out follows");
            chk(seg[1], 4'h1, "static hold");
        end
        tick(1);
        power[1] <= 1'b0;
        look(6);
        chk(seg[1], r, "static release");
        $display("test segment done");
        tick(1);
        hmPres <= 1'b0;
        for (int k = 0; k < 12; k++) begin
            tick(1);
            dip <= {2'h0, k[0], 1'b0, 4'(k)};
            look(5);
            chk(seg[0], dip_seg(4'(k)), "switch seg");
            chk(sda, !k[0], "speed detect");
        end
        tick(1);
        spdBad[3] <= 1'b1;
        look(3);
        chk(rate[3], 1'b0, "detect off");
        tick(1);
        dip <= 8'h05;
        look(3);
        chk(rate[3], 1'b1, "rate conflict");
        tick(1);
        hmPres <= 1'b1;
        jc <= 1'b0;
        look(5);
        chk(seg[0], 4'h1, "manager wins");
        chk(iso[N-2], 1'b1, "no jitter cleaner");
        $display("test config done");
        // Phantom mode needs no jitter cleaner, only ring-out phantom
        tick(1);
        sigMode <= 1'b0;
        roPh <= 1'b1;
        look(5);
        chk(riDrv, 1'b1, "ring-in phantom");
        chk(iso[N-1], 1'b0, "phantom insert");
        tick(1);
        dFlt <= 1'b1;
        tEn <= 2'h1;
        look(4);
        chk(iso[N-2], 1'b1, "drive fault wrap");
        chk(riDrv, 1'b0, "ring-in disabled");
        // Blamed beacon, ring heals: trunks held through the retest time
        tick(1);
        dFlt <= 1'b0;
        tEn <= 2'h3;
        blame <= 1'b1;
        recov <= 1'b1;
        tick(1);
        blame <= 1'b0;
        look(6);
        chk(rtp, 1'b1, "retest");
        chk(iso[N-1], 1'b1, "trunk held");
        look(22);
        chk(rtp, 1'b0, "retest over");
        chk(iso[N-1], 1'b0, "trunk retried");
        // Ring stays down: lobes are removed one by one
        tick(1);
        recov <= 1'b0;
        blame <= 1'b1;
        tick(1);
        blame <= 1'b0;
        look(14);
        chk(iso[1], 1'b1, "lobe removed");
        $display("test recovery done");
        report_and_stop();
    end
endmodule : rpw_wrap_ctrl_tb
